/* include/fcsr_pkg.sv */
// Package of constants for the flash command and status register block.
package fcsr_pkg;
  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam logic [7:0] FCSR_ADDR = 8'hE4;
  localparam logic [7:0] FCSR_RESET = 8'h00;
  localparam int FCSR_BIT_OI = 0;
  localparam int FCSR_BIT_SV = 1;
  localparam int FCSR_BIT_HVE = 2;
  localparam int FCSR_BIT_HVA = 3;
  localparam logic [3:0] FCSR_FLAGS_CLEAR = 4'h0;
  localparam logic [3:0] FCSR_RESERVED_READ = 4'h0;
  // ****************************************
  // Commands and page buffer
  // ****************************************
  localparam logic [7:0] FCSR_CMD_LOAD = 8'h00;
  localparam logic [7:0] FCSR_CMD_ERASE_PROGRAM = 8'h68;
  localparam int FCSR_PAGE_BYTES = 64;
  localparam int FCSR_PAGE_AW = 6;
  // ****************************************
  // Timing
  // ****************************************
  localparam int FCSR_CLK_HZ = 50000000;
  localparam int FCSR_ERASE_US = 2000;
  localparam int FCSR_PROGRAM_US = 2000;
  localparam int FCSR_ERASE_CYCLES = FCSR_ERASE_US * (FCSR_CLK_HZ / 1000000);
  localparam int FCSR_PROGRAM_CYCLES = FCSR_PROGRAM_US * (FCSR_CLK_HZ / 1000000);
  localparam int FCSR_TIMER_W = 17;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    FCSR_IDLE = 3'b001,
    FCSR_ERASE = 3'b010,
    FCSR_PROGRAM = 3'b100
  } fcsr_state_t;
endpackage

/* logic/fcsr_phase_timer.sv */
// Down counter that times one phase of the erase-program cycle.
`timescale 1ns/100ps
module fcsr_phase_timer
#(
  parameter int WIDTH = 17
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  // Status
  output logic done
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  always_comb
  begin
    count_next = count_reg;
    if (load)
    begin
      count_next = load_value;
    end
    else if (count_reg != '0)
    begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_reg <= '0;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  // Done only when the count reaches one, so a phase lasts exactly load_value cycles.
  assign done = (count_reg == {{(WIDTH-1){1'b0}}, 1'b1}) && !load;
endmodule

/* logic/fcsr_top.sv */
// Flash command and status register with page buffer and erase-program sequencer.
`timescale 1ns/100ps
module fcsr_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Special-function register access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  // Page buffer loading from the address and data registers
  input wire logic page_data_wr,
  input wire logic [5:0] page_index,
  input wire logic [7:0] page_data,
  // System events
  input wire logic interrupt_req,
  input wire logic reset_abort,
  input wire logic brownout_detect,
  input wire logic brownout_enabled,
  input wire logic hv_fault,
  input wire logic page_secured,
  input wire logic other_cmd_secured,
  // Register read data
  output logic [7:0] sfr_rdata,
  // Flash array write port
  output logic flash_erase,
  output logic flash_program,
  output logic [5:0] flash_index,
  output logic [7:0] flash_byte,
  output logic flash_byte_valid,
  // CPU control
  output logic cpu_idle
);
  // ****************************************
  // State
  // ****************************************
  fcsr_pkg::fcsr_state_t state_reg, state_next;
  logic [3:0] flags_reg, flags_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [5:0] scan_reg, scan_next;
  logic [7:0] page_mem [fcsr_pkg::FCSR_PAGE_BYTES];
  logic [fcsr_pkg::FCSR_PAGE_BYTES-1:0] upd_reg, upd_next;
  logic cmd_wr, busy, abort, timer_load, timer_done;
  logic [fcsr_pkg::FCSR_TIMER_W-1:0] timer_value;

  assign cmd_wr = sfr_wr && (sfr_addr == fcsr_pkg::FCSR_ADDR);
  assign busy = (state_reg != fcsr_pkg::FCSR_IDLE);
  // Reset is included so that a warm reset mid-cycle still leaves a trace.
  assign abort = busy && (interrupt_req || reset_abort || brownout_detect);

  fcsr_phase_timer #(.WIDTH(fcsr_pkg::FCSR_TIMER_W)) u_timer
  (
    .clk(clk),
    .rst_n(rst_n),
    .load(timer_load),
    .load_value(timer_value),
    .done(timer_done)
  );

  // ****************************************
  // Sequencer and status flags
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    flags_next = flags_reg;
    timer_load = 1'b0;
    timer_value = fcsr_pkg::FCSR_TIMER_W'(fcsr_pkg::FCSR_ERASE_CYCLES);
    upd_next = upd_reg;
    scan_next = scan_reg;
    if (cmd_wr && !busy)
    begin
      flags_next = fcsr_pkg::FCSR_FLAGS_CLEAR;
      if (sfr_wdata == fcsr_pkg::FCSR_CMD_LOAD)
      begin
        upd_next = '0;
      end
      else if (sfr_wdata == fcsr_pkg::FCSR_CMD_ERASE_PROGRAM)
      begin
        if (page_secured)
        begin
          flags_next[fcsr_pkg::FCSR_BIT_SV] = 1'b1;
        end
        else if (!brownout_enabled)
        begin
          flags_next[fcsr_pkg::FCSR_BIT_HVA] = 1'b1;
        end
        else
        begin
          state_next = fcsr_pkg::FCSR_ERASE;
          timer_load = 1'b1;
        end
      end
      else if (other_cmd_secured)
      begin
        // Other program, erase and CRC commands are executed elsewhere; only their security check lives here.
        flags_next[fcsr_pkg::FCSR_BIT_SV] = 1'b1;
      end
    end
    else if (page_data_wr && !busy)
    begin
      upd_next[page_index] = 1'b1;
    end
    unique case (state_reg)
      fcsr_pkg::FCSR_IDLE:
      begin
        scan_next = '0;
      end
      fcsr_pkg::FCSR_ERASE:
      begin
        scan_next = scan_reg + 1'b1;
        if (timer_done)
        begin
          state_next = fcsr_pkg::FCSR_PROGRAM;
          timer_load = 1'b1;
          timer_value = fcsr_pkg::FCSR_TIMER_W'(fcsr_pkg::FCSR_PROGRAM_CYCLES);
          scan_next = '0;
        end
      end
      fcsr_pkg::FCSR_PROGRAM:
      begin
        scan_next = scan_reg + 1'b1;
        if (timer_done)
        begin
          state_next = fcsr_pkg::FCSR_IDLE;
        end
      end
      default:
      begin
        state_next = fcsr_pkg::FCSR_IDLE;
      end
    endcase
    if (abort)
    begin
      state_next = fcsr_pkg::FCSR_IDLE;
      flags_next[fcsr_pkg::FCSR_BIT_OI] = 1'b1;
      flags_next[fcsr_pkg::FCSR_BIT_HVA] = interrupt_req || brownout_detect;
    end
    if (busy && hv_fault)
    begin
      flags_next[fcsr_pkg::FCSR_BIT_HVE] = 1'b1;
    end
  end

  // ****************************************
  // Read data and flash port
  // ****************************************
  always_comb
  begin
    rdata_next = rdata_reg;
    if (sfr_rd && (sfr_addr == fcsr_pkg::FCSR_ADDR))
    begin
      rdata_next = {fcsr_pkg::FCSR_RESERVED_READ, flags_reg};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= fcsr_pkg::FCSR_IDLE;
      flags_reg <= fcsr_pkg::FCSR_FLAGS_CLEAR;
      rdata_reg <= fcsr_pkg::FCSR_RESET;
      upd_reg <= '0;
      scan_reg <= '0;
      flash_erase <= 1'b0;
      flash_program <= 1'b0;
      flash_index <= '0;
      flash_byte <= fcsr_pkg::FCSR_RESET;
      flash_byte_valid <= 1'b0;
      cpu_idle <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      flags_reg <= flags_next;
      rdata_reg <= rdata_next;
      upd_reg <= upd_next;
      scan_reg <= scan_next;
      // Every byte is presented but only flagged bytes are marked valid; the array port sees each index once per pass.
      flash_erase <= (state_next == fcsr_pkg::FCSR_ERASE);
      flash_program <= (state_next == fcsr_pkg::FCSR_PROGRAM);
      flash_index <= scan_reg;
      flash_byte <= page_mem[scan_reg];
      // Gated by the next state so that no byte is flagged on the edge that ends or aborts a cycle.
      flash_byte_valid <= (state_next != fcsr_pkg::FCSR_IDLE) && upd_reg[scan_reg] && (scan_reg == scan_next - 1'b1);
      cpu_idle <= (state_next != fcsr_pkg::FCSR_IDLE);
    end
  end

  // Load and reset clear every byte, so a stale page never reaches the array port.
  always_ff @(posedge clk)
  begin
    if (!rst_n || (cmd_wr && !busy && (sfr_wdata == fcsr_pkg::FCSR_CMD_LOAD)))
    begin
      for (int i = 0; i < fcsr_pkg::FCSR_PAGE_BYTES; i++)
      begin
        page_mem[i] <= fcsr_pkg::FCSR_RESET;
      end
    end
    else if (page_data_wr && !busy)
    begin
      page_mem[page_index] <= page_data;
    end
  end

  assign sfr_rdata = rdata_reg;
endmodule

/* bench/fcsr_assertions.sv */
// Assertion checker for the flash command and status register.
`timescale 1ns/100ps
module fcsr_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // System events
  input wire logic interrupt_req,
  input wire logic reset_abort,
  input wire logic brownout_detect,
  input wire logic brownout_enabled,
  input wire logic hv_fault,
  input wire logic page_secured,
  // Flash port and CPU control
  input wire logic flash_erase,
  input wire logic flash_program,
  input wire logic flash_byte_valid,
  input wire logic cpu_idle
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic cmd_wr, ev;
  assign cmd_wr = sfr_wr && sfr_addr == 8'hE4 && !cpu_idle && sfr_wdata == 8'h68;
  assign ev = interrupt_req || reset_abort || brownout_detect;
  logic [16:0] erase_len;
  // A phase is far too long for a repetition, so a counter measures it.
  always_ff @(posedge clk)
  begin
    if (!rst_n || !flash_erase)
    begin
      erase_len <= '0;
    end
    else
    begin
      erase_len <= erase_len + 1'b1;
    end
  end
  erase_len_a: assert property (erase_len <= fcsr_pkg::FCSR_ERASE_CYCLES) else $error("Erase phase too long.");
  reserved_bits_a: assert property (sfr_rdata[7:4] == 4'h0) else $error("Reserved bits set.");
  cycle_start_a: assert property (cmd_wr && !page_secured && brownout_enabled && !ev |=>
    cpu_idle && flash_erase) else $error("Cycle did not start.");
  secured_refuse_a: assert property (cmd_wr && page_secured |=> !cpu_idle) else $error("Secured page ran.");
  bod_off_a: assert property (cmd_wr && !brownout_enabled |=> !cpu_idle) else $error("Ran without BOD.");
  abort_ends_a: assert property (cpu_idle && ev |=> !cpu_idle) else $error("Abort ignored.");
  hv_continue_a: assert property (cpu_idle && flash_erase && hv_fault && !ev |=> cpu_idle)
    else $error("Fault stopped cycle.");
  phase_excl_a: assert property (!(flash_erase && flash_program)) else $error("Both phases high.");
  valid_phase_a: assert property (flash_byte_valid |-> flash_erase || flash_program)
    else $error("Byte outside cycle.");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("Status changed.");
  cover property (cpu_idle && ev);
  cover property (cmd_wr && page_secured);
  cover property (flash_byte_valid);
endmodule
bind fcsr_top fcsr_checker fcsr_checker_inst (.clk, .rst_n, .sfr_wr, .sfr_rd, .interrupt_req, .reset_abort,
  .brownout_detect, .brownout_enabled, .hv_fault, .page_secured, .flash_erase, .flash_program,
  .flash_byte_valid, .cpu_idle, .sfr_addr, .sfr_wdata, .sfr_rdata);

/* bench/testbench.sv */
// Self-checking testbench for the flash command and status register.
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, page_data_wr = 0, interrupt_req = 0, reset_abort = 0;
  logic brownout_detect = 0, brownout_enabled = 1, hv_fault = 0, page_secured = 0, other_cmd_secured = 0;
  logic flash_erase, flash_program, flash_byte_valid, cpu_idle;
  logic [7:0] sfr_addr = 8'hE4, sfr_wdata = 8'h00, page_data = 8'hA5, sfr_rdata, flash_byte;
  logic [5:0] page_index = 6'h05, flash_index;
  logic [7:0] want [3] = '{8'h09, 8'h01, 8'h0D};
  int bad_count = 0, checked = 0, n;
  fcsr_top fcsr_top_inst
  (
    .clk(clk),
    .rst_n(rst_n),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .page_data_wr(page_data_wr),
    .page_index(page_index),
    .page_data(page_data),
    .interrupt_req(interrupt_req),
    .reset_abort(reset_abort),
    .brownout_detect(brownout_detect),
    .brownout_enabled(brownout_enabled),
    .hv_fault(hv_fault),
    .page_secured(page_secured),
    .other_cmd_secured(other_cmd_secured),
    .sfr_rdata(sfr_rdata),
    .flash_erase(flash_erase),
    .flash_program(flash_program),
    .flash_index(flash_index),
    .flash_byte(flash_byte),
    .flash_byte_valid(flash_byte_valid),
    .cpu_idle(cpu_idle)
  );
  initial
  begin
    forever #10 clk = ~clk;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    step(1);
    sfr_wr = 0;
  endtask
  // Read data is registered, so it is checked one edge after the strobe.
  task automatic rd(input logic [7:0] exp);
    sfr_addr = 8'hE4;
    sfr_rd = 1;
    step(1);
    sfr_rd = 0;
    chk("status", sfr_rdata, exp);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    step(5);
    rst_n = 1;
    rd(8'h00);
    $display("Test reset done");
    // A full cycle is 200000 edges, so every run here ends in an abort.
    for (int k = 0; k < 3; k++)
    begin
      wr(8'hE4, 8'h00);
      page_data_wr = (k == 0);
      step(1);
      page_data_wr = 0;
      wr(8'hE4, 8'h68);
      chk("start", {5'h00, flash_program, cpu_idle, flash_erase}, 8'h03);
      rd(8'h00);
      n = 0;
      repeat (64)
      begin
        step(1);
        if (k > 0 && flash_index === 6'h05)
        begin
          chk("cleared", flash_byte, 8'h00);
        end
        if (flash_byte_valid === 1'b1)
        begin
          n++;
          chk("index", {2'b00, flash_index}, 8'h05);
          chk("byte", flash_byte, 8'hA5);
        end
      end
      chk("valid", {7'h00, n != 0}, {7'h00, k == 0});
      if (k == 2)
      begin
        hv_fault = 1;
        step(1);
        hv_fault = 0;
        chk("busy", {7'h00, cpu_idle}, 8'h01);
      end
      case (k)
        0: interrupt_req = 1;
        1: reset_abort = 1;
        default: brownout_detect = 1;
      endcase
      step(1);
      {interrupt_req, reset_abort, brownout_detect} = 3'b000;
      chk("idle", {7'h00, cpu_idle}, 8'h00);
      rd(want[k]);
      step(20);
      rd(want[k]);
      $display("Test abort %0d done", k);
    end
    page_secured = 1;
    wr(8'hE4, 8'h68);
    page_secured = 0;
    rd(8'h02);
    brownout_enabled = 0;
    wr(8'hE4, 8'h68);
    brownout_enabled = 1;
    rd(8'h08);
    wr(8'hE5, 8'h00);
    rd(8'h08);
    other_cmd_secured = 1;
    wr(8'hE4, 8'h20);
    other_cmd_secured = 0;
    rd(8'h02);
    $display("Test refusals done");
    print_verdict();
  end
endmodule
